// ==== rtl/tpc_cfg.svh ====
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// Functional notes
// - One to eight channels, each capture, compare or edge PWM
// - Capture fires on rising, falling or either input edge
// - Compare match sets, clears or toggles the channel output
// - Module-wide buffered center-aligned PWM on all channels
// - Clock source bus, fixed or external, prescaled by 1 to 128
// - Counter runs on core clock; other sources synchronised to it
// - 16-bit counter, free running or modulo, up or up/down
// - One interrupt per channel plus one for overflow
// - Any counter byte write clears counter and prescaler
// - In debug, counter reads return frozen counter, not latch
// - In debug, writes to status/control or counter clear read latch
// - In debug, channel value reads return real contents
// - In debug, channel control write clears its value read latch
// - Channel value writes ignored in input capture mode
// - Compare mode loads buffered value at next counter change
// - Edge PWM loads buffer when counter steps modulo-1 to modulo, or to 0xFFFF free running
// - Center PWM loads buffer at same step, or to 0xFFFF free running
// - Center PWM: value equal modulo gives 100%, modulo-1 nearly 100%
// - Center PWM: zero to nonzero applies from next period
// - Center PWM: nonzero to zero finishes current period first
// - In debug, status/control write clears modulo write latch
// - Any status/control write resets channel value coherency
// - Capture inputs synchronised; shortest pulse four bus clocks
// - Edge PWM high at zero, low at match; low-true inverts
// - Debug freezes counter and prescaler
// Register byte offsets
`define TPC_SC_OFS 12'h000
`define TPC_CNTH_OFS 12'h004
`define TPC_CNTL_OFS 12'h008
`define TPC_MODH_OFS 12'h00C
`define TPC_MODL_OFS 12'h010
`define TPC_CH_BASE 8'h02
`define TPC_CH_SC_SUB 2'h0
`define TPC_CH_VH_SUB 2'h1
`define TPC_CH_VL_SUB 2'h2
// Module status/control fields
`define TPC_SC_TOF 7
`define TPC_SC_TOIE 6
`define TPC_SC_CTR_PWM 5
`define TPC_SC_CLKS 4:3
`define TPC_SC_PS 2:0
// Channel status/control fields
`define TPC_CSC_FLAG 7
`define TPC_CSC_IE 6
`define TPC_CSC_MS 5:4
`define TPC_CSC_ELS 3:2
// Constants
`define TPC_FREE_TOP 16'hFFFF
`define TPC_MAX_CH 8
`endif

// ==== rtl/tpc_pkg.sv ====
package tpc_pkg;
	typedef enum logic [3:0] {R_NONE, R_SC, R_CNTH, R_CNTL, R_MODH, R_MODL, R_CSC, R_CVH, R_CVL} tpc_reg_t;
	typedef struct packed {
		tpc_reg_t kind;
		logic [7:0] idx;
	} tpc_dec_t;
	typedef struct packed {
		logic flag;
		logic ie;
		logic [1:0] ms;
		logic [1:0] els;
		logic [15:0] cv;
		logic [15:0] vbuf;
		logic vhi;
		logic vpend;
		logic [7:0] vlat;
		logic vlat_ok;
		logic out;
		logic [2:0] sync;
	} tpc_ch_t;
endpackage : tpc_pkg

// ==== rtl/tpc_top.sv ====
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "tpc_cfg.svh"
module tpc_top import tpc_pkg::*; #(
	parameter int NCH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debug_halt_mode,
	input wire logic fixed_clk_in,
	input wire logic external_counter_clock_pin,
	input wire logic [NCH-1:0] channel_pin_in,
	output logic [NCH-1:0] channel_pin_out,
	output logic [NCH-1:0] channel_pin_oe,
	output logic [NCH-1:0] chan_irq,
	output logic ovf_irq
);
	// Refuse channel counts the decoder cannot serve
	if (NCH < 1 || NCH > `TPC_MAX_CH) begin : g_bad_nch
		$error("tpc_top: NCH must be 1 to 8");
	end

	typedef struct packed {
		logic tof;
		logic toie;
		logic ctr_pwm;
		logic [1:0] clks;
		logic [2:0] ps;
		logic [15:0] cnt;
		logic down;
		logic [6:0] presc;
		logic [15:0] mod;
		logic [7:0] mbuf;
		logic mhi;
		logic [7:0] clat;
		logic clat_ok;
		logic bus_ph;
		logic [2:0] fsync;
		logic [2:0] esync;
		logic [7:0] rdata;
		logic err;
		tpc_ch_t [NCH-1:0] ch;
	} tpc_st_t;

	// Address decode, also used by the checks
	function automatic tpc_dec_t tpc_decode(input logic [11:0] a);
		tpc_dec_t r;
		r.kind = R_NONE;
		r.idx = 8'h00;
		case (a)
			`TPC_SC_OFS: r.kind = R_SC;
			`TPC_CNTH_OFS: r.kind = R_CNTH;
			`TPC_CNTL_OFS: r.kind = R_CNTL;
			`TPC_MODH_OFS: r.kind = R_MODH;
			`TPC_MODL_OFS: r.kind = R_MODL;
			default: begin
				r.idx = a[11:4] - `TPC_CH_BASE;
				if (a[11:4] >= `TPC_CH_BASE && r.idx < 8'(NCH) && a[1:0] == 2'h0) begin
					case (a[3:2])
						`TPC_CH_SC_SUB: r.kind = R_CSC;
						`TPC_CH_VH_SUB: r.kind = R_CVH;
						`TPC_CH_VL_SUB: r.kind = R_CVL;
						default: r.kind = R_NONE;
					endcase
				end
			end
		endcase
		return r;
	endfunction : tpc_decode

	tpc_st_t st;
	tpc_st_t next_st;
	tpc_dec_t dec;
	logic setup;
	logic wr;
	logic dbg;
	logic src;
	logic tick;
	logic tof_set;
	logic ldwin;
	logic [15:0] top;
	logic [15:0] ncnt;
	logic [7:0] m8;
	logic [7:0] w;

	assign dec = tpc_decode(paddr);
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign dbg = debug_halt_mode;
	assign w = pwdata[7:0];

	// Next-state logic: clock, counter, bus, channels
	always_comb begin
		next_st = st;
		next_st.bus_ph = ~st.bus_ph;
		next_st.fsync = {st.fsync[1:0], fixed_clk_in};
		next_st.esync = {st.esync[1:0], external_counter_clock_pin};
		// Source pulse on the core clock
		case (st.clks)
			2'h1: src = st.bus_ph;
			2'h2: src = st.fsync[1] & ~st.fsync[2];
			2'h3: src = st.esync[1] & ~st.esync[2];
			default: src = 1'b0;
		endcase
		// Prescaler taps 1..128
		m8 = (8'h01 << st.ps) - 8'h01;
		tick = src & ~dbg & ((st.presc & m8[6:0]) == m8[6:0]);
		if (src && !dbg) begin
			next_st.presc = st.presc + 7'h01;
		end
		top = (st.mod == 16'h0000 || st.mod == `TPC_FREE_TOP) ? `TPC_FREE_TOP : st.mod;
		ldwin = tick & ~st.down & (st.cnt == top - 16'h0001);
		// Counter step, up or up/down
		ncnt = st.cnt;
		tof_set = 1'b0;
		if (tick) begin
			if (st.ctr_pwm && st.down) begin
				if (st.cnt == 16'h0000) begin
					next_st.down = 1'b0;
					ncnt = st.cnt + 16'h0001;
				end else begin
					ncnt = st.cnt - 16'h0001;
				end
			end else if (st.cnt >= top) begin
				tof_set = 1'b1;
				if (st.ctr_pwm) begin
					next_st.down = 1'b1;
					ncnt = st.cnt - 16'h0001;
				end else begin
					ncnt = 16'h0000;
				end
			end else begin
				ncnt = st.cnt + 16'h0001;
			end
		end
		next_st.cnt = ncnt;
		// Register writes in the access phase
		if (wr) begin
			case (dec.kind)
				R_SC: begin
					next_st.toie = w[`TPC_SC_TOIE];
					next_st.ctr_pwm = w[`TPC_SC_CTR_PWM];
					next_st.clks = w[`TPC_SC_CLKS];
					next_st.ps = w[`TPC_SC_PS];
					if (!w[`TPC_SC_TOF]) begin
						next_st.tof = 1'b0;
					end
					for (int i = 0; i < NCH; i++) begin
						next_st.ch[i].vhi = 1'b0;
						next_st.ch[i].vpend = 1'b0;
					end
					if (dbg) begin
						next_st.clat_ok = 1'b0;
						next_st.mhi = 1'b0;
					end
				end
				R_CNTH, R_CNTL: begin
					next_st.cnt = 16'h0000;
					next_st.presc = 7'h00;
					next_st.down = 1'b0;
					if (dbg) begin
						next_st.clat_ok = 1'b0;
					end
				end
				R_MODH: begin
					next_st.mbuf = w;
					next_st.mhi = 1'b1;
				end
				R_MODL: begin
					next_st.mod = {st.mhi ? st.mbuf : st.mod[15:8], w};
					next_st.mhi = 1'b0;
				end
				R_CSC: begin
					next_st.ch[dec.idx].ie = w[`TPC_CSC_IE];
					next_st.ch[dec.idx].ms = w[`TPC_CSC_MS];
					next_st.ch[dec.idx].els = w[`TPC_CSC_ELS];
					if (!w[`TPC_CSC_FLAG]) begin
						next_st.ch[dec.idx].flag = 1'b0;
					end
					if (dbg) begin
						next_st.ch[dec.idx].vlat_ok = 1'b0;
					end
				end
				R_CVH: begin
					if (st.ctr_pwm || st.ch[dec.idx].ms != 2'h0) begin
						next_st.ch[dec.idx].vbuf[15:8] = w;
						next_st.ch[dec.idx].vhi = 1'b1;
					end
				end
				R_CVL: begin
					if (st.ctr_pwm || st.ch[dec.idx].ms != 2'h0) begin
						next_st.ch[dec.idx].vbuf[7:0] = w;
						if (st.ch[dec.idx].vhi) begin
							next_st.ch[dec.idx].vhi = 1'b0;
							if (st.clks == 2'h0) begin
								next_st.ch[dec.idx].cv = {st.ch[dec.idx].vbuf[15:8], w};
							end else begin
								next_st.ch[dec.idx].vpend = 1'b1;
							end
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Read data sampled in the setup phase
		if (setup) begin
			next_st.err = (dec.kind == R_NONE);
			case (dec.kind)
				R_SC: next_st.rdata = {st.tof, st.toie, st.ctr_pwm, st.clks, st.ps};
				R_CNTH: begin
					next_st.rdata = st.cnt[15:8];
					if (!dbg) begin
						next_st.clat = st.cnt[7:0];
						next_st.clat_ok = 1'b1;
					end
				end
				R_CNTL: begin
					next_st.rdata = (st.clat_ok && !dbg) ? st.clat : st.cnt[7:0];
					next_st.clat_ok = 1'b0;
				end
				R_MODH: next_st.rdata = st.mod[15:8];
				R_MODL: next_st.rdata = st.mod[7:0];
				R_CSC: next_st.rdata = {st.ch[dec.idx].flag, st.ch[dec.idx].ie, st.ch[dec.idx].ms,
					st.ch[dec.idx].els, 2'h0};
				R_CVH: begin
					next_st.rdata = st.ch[dec.idx].cv[15:8];
					if (!dbg) begin
						next_st.ch[dec.idx].vlat = st.ch[dec.idx].cv[7:0];
						next_st.ch[dec.idx].vlat_ok = 1'b1;
					end
				end
				R_CVL: begin
					next_st.rdata = (st.ch[dec.idx].vlat_ok && !dbg) ? st.ch[dec.idx].vlat
						: st.ch[dec.idx].cv[7:0];
					next_st.ch[dec.idx].vlat_ok = 1'b0;
				end
				default: next_st.rdata = 8'h00;
			endcase
		end
		next_st.tof = next_st.tof | tof_set;
		// Per-channel behaviour
		for (int i = 0; i < NCH; i++) begin
			next_st.ch[i].sync = {st.ch[i].sync[1:0], channel_pin_in[i]};
			if (!st.ctr_pwm && st.ch[i].ms == 2'h0) begin
				// Input capture on selected edge
				if ((st.ch[i].els[0] && st.ch[i].sync[1] && !st.ch[i].sync[2]) ||
					(st.ch[i].els[1] && !st.ch[i].sync[1] && st.ch[i].sync[2])) begin
					next_st.ch[i].cv = st.cnt;
					next_st.ch[i].flag = 1'b1;
				end
			end else begin
				// Buffered loads
				if (st.ch[i].vpend && tick && (ldwin || (!st.ctr_pwm && st.ch[i].ms == 2'h1))) begin
					next_st.ch[i].cv = st.ch[i].vbuf;
					next_st.ch[i].vpend = 1'b0;
				end
				if (tick && ncnt == st.ch[i].cv) begin
					next_st.ch[i].flag = 1'b1;
				end
				if (st.ctr_pwm) begin
					// Center PWM, full duty at cv equal top
					next_st.ch[i].out = ((st.cnt < st.ch[i].cv) || st.ch[i].cv == top) ^ st.ch[i].els[0];
				end else if (st.ch[i].ms[1]) begin
					next_st.ch[i].out = (st.cnt < st.ch[i].cv) ^ st.ch[i].els[0];
				end else if (tick && ncnt == st.ch[i].cv) begin
					// Compare action
					case (st.ch[i].els)
						2'h1: next_st.ch[i].out = ~st.ch[i].out;
						2'h2: next_st.ch[i].out = 1'b0;
						2'h3: next_st.ch[i].out = 1'b1;
						default: next_st.ch[i].out = st.ch[i].out;
					endcase
				end
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Bus answer, zero wait states
	assign pready = 1'b1;
	assign pslverr = psel & penable & st.err;
	assign prdata = {24'h000000, st.rdata};
	assign ovf_irq = st.tof & st.toie;

	// Pins and channel interrupts
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign channel_pin_out[g] = st.ch[g].out;
		// Pin driven only with a clock, an edge field and no capture
		assign channel_pin_oe[g] = (st.clks != 2'h0) && (st.ch[g].els != 2'h0)
			&& (st.ctr_pwm || st.ch[g].ms != 2'h0);
		assign chan_irq[g] = st.ch[g].flag & st.ch[g].ie;
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_cnt_clear: assert property (wr && (dec.kind == R_CNTH || dec.kind == R_CNTL)
		|=> st.cnt == 16'h0000 && st.presc == 7'h00) else $error("counter write did not clear");
	chk_dbg_freeze: assert property (dbg && !wr |=> $stable(st.cnt))
		else $error("counter moved in debug");
	chk_cap_ignore: assert property (wr && dec.kind == R_CVL && !st.ctr_pwm
		&& st.ch[0].ms == 2'h0 && dec.idx == 8'h00
		|=> $stable(st.ch[0].vbuf)) else $error("capture channel accepted value write");
	chk_top_wrap: assert property (tick && !st.ctr_pwm && st.cnt == top && !wr
		|=> st.cnt == 16'h0000 && st.tof) else $error("no wrap or overflow flag at top");
	chk_sc_coh: assert property (wr && dec.kind == R_SC |=> !st.ch[0].vpend && !st.ch[0].vhi)
		else $error("control write kept value coherency");
	chk_dbg_cnt_rd: assert property (setup && dbg && dec.kind == R_CNTL
		|=> st.rdata == $past(st.cnt[7:0])) else $error("debug counter read not live");
	chk_mod_latch: assert property (wr && dbg && dec.kind == R_SC |=> !st.mhi)
		else $error("modulo write latch kept in debug");
	chk_oc_load: assert property (tick && !st.ctr_pwm && st.ch[0].ms == 2'h1 && st.ch[0].vpend
		&& !wr |=> st.ch[0].cv == $past(st.ch[0].vbuf) && !st.ch[0].vpend)
		else $error("compare buffer not loaded");
	chk_ctr_full: assert property (st.ctr_pwm && st.ch[0].els == 2'h2 && st.ch[0].cv == top
		&& $stable(top) |=> st.ch[0].out) else $error("full duty not high");

	// Main scenarios reached
	cov_wrap: cover property (tick && st.cnt == top);
	cov_capture: cover property (!st.ctr_pwm && st.ch[0].ms == 2'h0 && $rose(st.ch[0].flag));
	cov_ctr_turn: cover property (st.ctr_pwm && $rose(st.down));
	cov_oc_load: cover property (tick && !st.ctr_pwm && st.ch[0].ms == 2'h1 && st.ch[0].vpend);
	cov_dbg_read: cover property (setup && dbg && dec.kind == R_CNTL);
endmodule : tpc_top

// ==== tb/tpc_pin_model.sv ====
`timescale 1ns/10ps
// Far-side pins: capture inputs and counter clock sources
module tpc_pin_model (
	input wire logic pclk,
	output logic [1:0] pin_drive,
	output logic fixed_clk,
	output logic ext_clk
);
	// Idle levels from time zero
	initial begin
		pin_drive = 2'h0;
		fixed_clk = 1'b0;
		ext_clk = 1'b0;
	end
	// New pin level, held well past the shortest detectable pulse
	task automatic set_pin(input int ch, input logic v);
		@(posedge pclk);
		pin_drive[ch] <= v;
		repeat (10) @(posedge pclk);
	endtask : set_pin
	// Burst of source edges, eight cycles per phase, still between bursts
	task automatic burst(input logic ext, input int n);
		repeat (n) begin
			repeat (8) @(posedge pclk);
			if (ext) ext_clk <= 1'b1;
			else fixed_clk <= 1'b1;
			repeat (8) @(posedge pclk);
			ext_clk <= 1'b0;
			fixed_clk <= 1'b0;
		end
	endtask : burst
endmodule : tpc_pin_model

// ==== tb/tb_timer_pwm_capture_unit.sv ====
`timescale 1ns/10ps
module tb_timer_pwm_capture_unit import tpc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, debug_halt_mode, pready, pslverr, err, fclk, eclk, ovf;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] v16;
	logic [1:0] drive, pin, pout, poe, cirq;
	int fail_count, compares, cyc, hi, cv, exp_v;
	// Clock and pin wire level
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	assign pin = (poe & pout) | (~poe & drive);
	tpc_top #(.NCH(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_halt_mode(debug_halt_mode), .fixed_clk_in(fclk), .external_counter_clock_pin(eclk),
		.channel_pin_in(pin), .channel_pin_out(pout), .channel_pin_oe(poe), .chan_irq(cirq), .ovf_irq(ovf));
	tpc_pin_model pm (.pclk(pclk), .pin_drive(drive), .fixed_clk(fclk), .ext_clk(eclk));
	// One bus transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Byte pairs, high byte first
	task automatic wr16(input logic [11:0] a, input logic [15:0] v);
		apb(1'b1, a, {24'h0, v[15:8]});
		apb(1'b1, a + 12'h004, {24'h0, v[7:0]});
	endtask : wr16
	task automatic rd16(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
		v16[15:8] = rd[7:0];
		apb(1'b0, a + 12'h004, 32'h0);
		v16[7:0] = rd[7:0];
	endtask : rd16
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// High cycles of channel 0 over a window
	task automatic meas(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge pclk);
			hi += int'(pout[0]);
		end
	endtask : meas
	task automatic close_out();
		$display("Mismatches %0d, comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			close_out();
		end
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, presetn, debug_halt_mode} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		{cyc, fail_count, compares} = 0;
		void'($urandom(32'h4871633A));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
		// Capture mode drops value writes; compare mode takes them at once
		wr16(12'h034, 16'h0);
		apb(1'b1, 12'h030, 32'h04);
		cv = $urandom_range(16'hFFFF, 1);
		wr16(12'h034, cv[15:0]);
		rd16(12'h034);
		chk(v16, 32'h0);
		wr16(12'h024, cv[15:0]);
		rd16(12'h024);
		chk(v16, 32'h0);
		apb(1'b1, 12'h030, 32'h1C);
		wr16(12'h034, cv[15:0]);
		rd16(12'h034);
		chk(v16, cv);
		// Every capture edge choice against both pin edges
		apb(1'b1, 12'h000, 32'h08);
		for (int e = 1; e < 4; e++) begin
			apb(1'b1, 12'h020, 32'h40 | (e << 2));
			pm.set_pin(0, 1'b1);
			apb(1'b0, 12'h020, 32'h0);
			chk(rd[7], e & 1);
			chk(cirq[0], e & 1);
			apb(1'b1, 12'h020, 32'h40 | (e << 2));
			pm.set_pin(0, 1'b0);
			apb(1'b0, 12'h020, 32'h0);
			chk(rd[7], e >> 1);
		end
		// Counter clear, then fixed and external sources counted edge by edge
		for (int s = 2; s < 4; s++) begin
			apb(1'b1, 12'h000, 32'h0);
			apb(1'b1, 12'h008, 32'hA5);
			apb(1'b1, 12'h000, s << 3);
			cv = $urandom_range(12, 3);
			pm.burst(s == 3, cv);
			repeat (10) @(posedge pclk);
			rd16(12'h004);
			chk(v16, cv);
		end
		// Debug halt freezes the count; counter write still clears
		apb(1'b1, 12'h000, 32'h08);
		repeat (30) @(posedge pclk);
		debug_halt_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		rd16(12'h004);
		exp_v = v16;
		repeat (40) @(posedge pclk);
		rd16(12'h004);
		chk(v16, exp_v);
		apb(1'b1, 12'h004, 32'h5A);
		rd16(12'h004);
		chk(v16, 32'h0);
		// Control write in debug drops a half-written modulo
		apb(1'b1, 12'h00C, 32'h12);
		apb(1'b1, 12'h000, 32'h08);
		apb(1'b1, 12'h010, 32'h09);
		rd16(12'h00C);
		chk(v16, 32'h0009);
		debug_halt_mode <= 1'b0;
		// Compare match sets, then clears, the output
		apb(1'b1, 12'h000, 32'h0);
		wr16(12'h00C, 16'h0009);
		apb(1'b1, 12'h020, 32'h1C);
		wr16(12'h024, 16'h0005);
		apb(1'b1, 12'h000, 32'h08);
		repeat (60) @(posedge pclk);
		chk(pout[0], 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd[7], 32'h1);
		apb(1'b1, 12'h020, 32'h18);
		repeat (60) @(posedge pclk);
		chk(pout[0], 32'h0);
		// Running compare takes the buffered value at the next count
		wr16(12'h024, 16'h0003);
		repeat (4) @(posedge pclk);
		rd16(12'h024);
		chk(v16, 32'h0003);
		// Edge PWM duty over prescaler and polarity; period 20 cycles times 2^ps
		for (int ps = 0; ps < 3; ps++) begin
			for (int pol = 0; pol < 2; pol++) begin
				apb(1'b1, 12'h000, 32'h0);
				cv = $urandom_range(8, 1);
				apb(1'b1, 12'h020, pol ? 32'h24 : 32'h28);
				wr16(12'h024, cv[15:0]);
				apb(1'b1, 12'h000, 32'h48 | ps);
				repeat (40 << ps) @(posedge pclk);
				meas(80 << ps);
				chk(hi, ((pol ? 10 - cv : cv) * 8) << ps);
				chk(ovf, 32'h1);
			end
		end
		// Buffered value waits for both bytes, then the top step
		exp_v = (cv % 8) + 1;
		apb(1'b1, 12'h024, 32'h0);
		repeat (160) @(posedge pclk);
		meas(320);
		chk(hi, (10 - cv) * 32);
		apb(1'b1, 12'h028, exp_v);
		repeat (160) @(posedge pclk);
		meas(320);
		chk(hi, (10 - exp_v) * 32);
		// Center-aligned: control first, then value; at modulo full duty, zero none
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h020, 32'h08);
		apb(1'b1, 12'h000, 32'h20);
		wr16(12'h024, 16'h0009);
		apb(1'b1, 12'h000, 32'h28);
		repeat (80) @(posedge pclk);
		meas(72);
		chk(hi, 32'd72);
		wr16(12'h024, 16'h0000);
		repeat (80) @(posedge pclk);
		meas(72);
		chk(hi, 32'h0);
		close_out();
	end
endmodule : tb_timer_pwm_capture_unit
